// ===== shared/lbr_pkg.sv
// Shared constants and types for the AXI4-Lite block RAM controller.
// Assumes one clock (pclk) for the AXI4-Lite side, APB side and memory ports.

package lbr_pkg;

   // -------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------
   localparam int LBR_PADDR_W = 12;
   localparam logic [11:0] LBR_MASK_OFS = 12'h000;
   localparam logic [11:0] LBR_STAT_OFS = 12'h004;
   localparam int LBR_MASK_MAX_W = 9;
   localparam logic [8:0] LBR_MASK_RST = 9'h000;
   localparam logic [31:0] LBR_RDATA_RST = 32'h00000000;

   // Status register field positions.
   localparam int LBR_STAT_BUSY = 0;
   localparam int LBR_STAT_RMW = 1;
   localparam int LBR_STAT_ECC = 2;
   localparam int LBR_STAT_FI = 3;
   localparam int LBR_STAT_SP = 4;

   // AXI response codes.
   localparam logic [1:0] LBR_RESP_OKAY = 2'h0;

   // Check-bit width for each supported data width.
   localparam int LBR_CHK_W32 = 7;
   localparam int LBR_CHK_W64 = 8;
   localparam int LBR_CHK_W128 = 9;

   // Controller state that software can observe.
   typedef struct packed {
      logic single_port;
      logic fi_on;
      logic ecc_on;
      logic read_modify_write_cycle;
      logic busy;
   } lbr_stat_t;

endpackage : lbr_pkg

// ===== src/lbr_ecc_enc.sv
// Hamming check-bit generator with an overall parity bit (SEC-DED).
// Purely combinational; the caller registers its result.
`timescale 1ns/100ps

module lbr_ecc_enc
   import lbr_pkg::*;
#(
   parameter int DATA_W = 32,
   parameter int CHK_W = 7
) (
   input wire logic [DATA_W-1:0] data_in, // Data word to protect.
   output logic [CHK_W-1:0] chk_out // Check bits for the word.
);

   // Hamming position of data bit i, skipping power-of-two slots.
   function automatic int dpos(input int i);
      int n;
      int p;
      n = 0;
      dpos = 0;
      for (p = 1; p < 512; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (n == i) begin
               dpos = p;
               break;
            end
            n++;
         end
      end
   endfunction : dpos

   // Parity over positions sharing each address bit, then overall parity.
   always_comb begin
      logic [CHK_W-1:0] c;
      c = '0;
      for (int j = 0; j < CHK_W - 1; j++) begin
         for (int i = 0; i < DATA_W; i++) begin
            if (((dpos(i) >> j) & 1) == 1) begin
               c[j] = c[j] ^ data_in[i];
            end
         end
      end
      c[CHK_W-1] = (^data_in) ^ (^c[CHK_W-2:0]);
      chk_out = c;
   end

endmodule : lbr_ecc_enc

// ===== src/lbr_apb_regs.sv
// APB register slave: check-bit fault mask and controller status.
// Assumes an APB master on pclk; answers in the second access cycle.
`timescale 1ns/100ps

module lbr_apb_regs
   import lbr_pkg::*;
#(
   parameter int CHK_W = 7,
   parameter bit MASK_EN = 1'b1
) (
   input wire logic pclk, // Bus clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic psel, // Slave select.
   input wire logic penable, // Access phase.
   input wire logic pwrite, // Write when high.
   input wire logic [LBR_PADDR_W-1:0] paddr, // Byte address.
   input wire logic [31:0] pwdata, // Write data.
   output logic pready, // Transfer done.
   output logic [31:0] prdata, // Read data.
   output logic pslverr, // Unmapped address or absent register.
   input wire logic mask_clear, // Corrupted check bits have been written.
   input wire lbr_stat_t status, // Controller state.
   output logic [LBR_MASK_MAX_W-1:0] mask // Check-bit fault mask.
);

   logic next_pready;
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic [LBR_MASK_MAX_W-1:0] next_mask;
   logic hit_mask;
   logic hit_stat;
   logic mask_wr;

   // An absent mask register decodes as unmapped.
   assign hit_mask = MASK_EN && (paddr == LBR_MASK_OFS);
   assign hit_stat = (paddr == LBR_STAT_OFS);
   assign mask_wr = psel && penable && pready && pwrite && hit_mask;

   // Decode in the first access cycle; answer and commit in the second.
   always_comb begin
      next_pready = psel && penable && !pready;
      next_prdata = prdata;
      next_pslverr = 1'b0;
      next_mask = mask;
      if (psel && penable && !pready) begin
         next_prdata = '0;
         next_pslverr = !(hit_mask || hit_stat);
         if (hit_mask) begin
            next_prdata[CHK_W-1:0] = mask[CHK_W-1:0];
         end else if (hit_stat) begin
            next_prdata[LBR_STAT_BUSY] = status.busy;
            next_prdata[LBR_STAT_RMW] = status.read_modify_write_cycle;
            next_prdata[LBR_STAT_ECC] = status.ecc_on;
            next_prdata[LBR_STAT_FI] = status.fi_on;
            next_prdata[LBR_STAT_SP] = status.single_port;
         end
      end
      // A software write in the clearing cycle wins, so a fresh mask is not lost.
      if (mask_wr) begin
         next_mask = '0;
         next_mask[CHK_W-1:0] = pwdata[CHK_W-1:0];
      end else if (mask_clear) begin
         next_mask = LBR_MASK_RST;
      end
   end

   // Register stage.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= LBR_RDATA_RST;
         pslverr <= 1'b0;
         mask <= LBR_MASK_RST;
      end else begin
         pready <= next_pready;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
         mask <= next_mask;
      end
   end

   AST_MASK_SELF_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      (mask_clear && !mask_wr) |=> (mask == LBR_MASK_RST))
      else $error("Fault mask not cleared after injection.");

   AST_MASK_ABSENT: assert property (@(posedge pclk) disable iff (!presetn)
      !MASK_EN |-> (mask == LBR_MASK_RST) && !(pready && hit_mask && !pslverr))
      else $error("Absent fault mask register responded.");

   AST_MASK_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
      (pready && !pwrite && hit_mask) |-> (prdata >> CHK_W) == 32'h00000000)
      else $error("Reserved mask bits read nonzero.");

endmodule : lbr_apb_regs

// ===== src/lbr_ctrl.sv
// AXI4-Lite slave that serves single reads and writes to block RAM.
// Optional ECC turns each write into a read-modify-write and a check-bit
// fault mask, reached over APB, corrupts the next written check bits.
// Assumes synchronous block RAM clocked by pclk with one cycle read latency,
// and an AXI4-Lite master on the same clock.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps

module lbr_ctrl
   import lbr_pkg::*;
#(
   parameter int DATA_W = 32,
   parameter int ADDR_W = 32,
   parameter int MEM_AW = 11,
   parameter bit LITE_PROTOCOL = 1'b1,
   parameter bit ECC_ON = 1'b1,
   parameter bit FAULT_INJ = 1'b1,
   parameter bit SINGLE_PORT = 1'b1,
   localparam int CHK_W = (DATA_W == 32) ? LBR_CHK_W32 :
      (DATA_W == 64) ? LBR_CHK_W64 : LBR_CHK_W128,
   localparam int MEM_W = DATA_W + CHK_W,
   localparam int BE_W = DATA_W / 8
) (
   input wire logic pclk, // Bus clock, 10 MHz.
   input wire logic presetn, // Asynchronous reset, active low.
   // APB register port.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pwrite, // APB write.
   input wire logic [LBR_PADDR_W-1:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic pready, // APB ready.
   output logic [31:0] prdata, // APB read data.
   output logic pslverr, // APB error.
   // AXI4-Lite slave.
   input wire logic [ADDR_W-1:0] s_awaddr, // Write address.
   input wire logic s_awvalid, // Write address valid.
   output logic s_awready, // Write address ready.
   input wire logic [DATA_W-1:0] s_wdata, // Write data.
   input wire logic [BE_W-1:0] s_wstrb, // Write byte strobes.
   input wire logic s_wvalid, // Write data valid.
   output logic s_wready, // Write data ready.
   output logic [1:0] s_bresp, // Write response.
   output logic s_bvalid, // Write response valid.
   input wire logic s_bready, // Write response ready.
   input wire logic [ADDR_W-1:0] s_araddr, // Read address.
   input wire logic s_arvalid, // Read address valid.
   output logic s_arready, // Read address ready.
   output logic [DATA_W-1:0] s_rdata, // Read data.
   output logic [1:0] s_rresp, // Read response.
   output logic s_rlast, // Last read beat.
   output logic s_rvalid, // Read data valid.
   input wire logic s_rready, // Read data ready.
   // Memory port A: all writes and read-modify-write reads, and AXI reads with one port.
   output logic memory_port_a_enable, // Port A enable.
   output logic [BE_W-1:0] mem_a_we, // Port A byte write enables.
   output logic [MEM_AW-1:0] memory_port_a_address, // Port A word address.
   output logic [MEM_W-1:0] mem_a_wdata, // Port A write data, check bits on top.
   input wire logic [MEM_W-1:0] memory_port_a_read_data, // Port A read data.
   // Memory port B: reads with two ports.
   output logic mem_b_en, // Port B enable.
   output logic [MEM_AW-1:0] mem_b_addr, // Port B word address.
   input wire logic [MEM_W-1:0] mem_b_rdata // Port B read data.
);

   localparam int LSB = $clog2(BE_W);
   localparam bit MASK_EN = FAULT_INJ && ECC_ON;

   // -------------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------------
   // Only the reduced protocol is built here.
   if (!LITE_PROTOCOL) begin : g_bad_proto
      $error("Only the AXI4-Lite variant is supported.");
   end
   if (DATA_W != 32 && DATA_W != 64 && DATA_W != 128) begin : g_bad_w
      $error("DATA_W must be 32, 64 or 128.");
   end
   if (ADDR_W < MEM_AW + LSB) begin : g_bad_a
      $error("ADDR_W too small for MEM_AW.");
   end

   // -------------------------------------------------------------------
   // Datapath helpers
   // -------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE, ST_RD_ADDR, ST_RD_DATA, ST_RD_RESP, ST_WR_ACC,
      ST_RMW_RD, ST_RMW_MRG, ST_RMW_WR, ST_WR_RESP
   } lbr_state_t;

   lbr_state_t st;
   lbr_state_t next_st;
   logic next_arready;
   logic next_awready;
   logic next_wready;
   logic next_bvalid;
   logic next_rvalid;
   logic [DATA_W-1:0] next_rdata;
   logic next_a_en;
   logic [BE_W-1:0] next_a_we;
   logic [MEM_AW-1:0] next_a_addr;
   logic [MEM_W-1:0] next_a_wdata;
   logic next_b_en;
   logic [MEM_AW-1:0] next_b_addr;
   logic next_inj_done;
   logic inj_done;
   logic start_wr;
   logic [DATA_W-1:0] merged;
   logic [CHK_W-1:0] enc_chk;
   logic [LBR_MASK_MAX_W-1:0] mask;
   logic [CHK_W-1:0] mask_eff;
   logic [DATA_W-1:0] rd_src;
   logic [MEM_AW-1:0] raddr_w;
   logic [MEM_AW-1:0] waddr_w;
   lbr_stat_t status;

   assign raddr_w = s_araddr[LSB +: MEM_AW];
   assign waddr_w = s_awaddr[LSB +: MEM_AW];
   assign mask_eff = MASK_EN ? mask[CHK_W-1:0] : '0;
   // Read data source follows the port plan.
   assign rd_src = SINGLE_PORT ? memory_port_a_read_data[DATA_W-1:0] :
      mem_b_rdata[DATA_W-1:0];

   // Merge the strobed bytes of the new data over the old word.
   for (genvar b = 0; b < BE_W; b++) begin : g_merge
      assign merged[b*8 +: 8] = s_wstrb[b] ? s_wdata[b*8 +: 8] :
         memory_port_a_read_data[b*8 +: 8];
   end

   lbr_ecc_enc #(
      .DATA_W(DATA_W),
      .CHK_W(CHK_W)
   ) u_enc (
      .data_in(merged),
      .chk_out(enc_chk)
   );

   assign status.busy = (st != ST_IDLE);
   assign status.read_modify_write_cycle = (st == ST_RMW_RD) || (st == ST_RMW_MRG) || (st == ST_RMW_WR);
   assign status.ecc_on = ECC_ON;
   assign status.fi_on = MASK_EN;
   assign status.single_port = SINGLE_PORT;

   lbr_apb_regs #(
      .CHK_W(CHK_W),
      .MASK_EN(MASK_EN)
   ) u_regs (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pready(pready),
      .prdata(prdata),
      .pslverr(pslverr),
      .mask_clear(inj_done),
      .status(status),
      .mask(mask)
   );

   // -------------------------------------------------------------------
   // Transaction engine
   // -------------------------------------------------------------------
   // One transaction at a time; the address channels are the only arbiter,
   // so a single memory port never sees two requests at once.
   always_comb begin
      next_st = st;
      next_arready = 1'b0;
      next_awready = 1'b0;
      next_wready = 1'b0;
      next_bvalid = s_bvalid;
      next_rvalid = s_rvalid;
      next_rdata = s_rdata;
      next_a_en = 1'b0;
      next_a_we = '0;
      next_a_addr = memory_port_a_address;
      next_a_wdata = mem_a_wdata;
      next_b_en = 1'b0;
      next_b_addr = mem_b_addr;
      next_inj_done = 1'b0;
      start_wr = 1'b0;
      case (st)
         ST_IDLE: begin
            // Reads win over simultaneous writes.
            if (s_arvalid) begin
               next_arready = 1'b1;
               if (SINGLE_PORT) begin
                  next_a_en = 1'b1;
                  next_a_addr = raddr_w;
               end else begin
                  next_b_en = 1'b1;
                  next_b_addr = raddr_w;
               end
               next_st = ST_RD_ADDR;
            end else if (s_awvalid && s_wvalid) begin
               start_wr = 1'b1;
            end
         end
         ST_RD_ADDR: begin
            next_st = ST_RD_DATA;
         end
         ST_RD_DATA: begin
            next_rdata = rd_src;
            next_rvalid = 1'b1;
            next_st = ST_RD_RESP;
         end
         ST_RD_RESP: begin
            if (s_rready) begin
               next_rvalid = 1'b0;
               next_st = ST_IDLE;
            end
         end
         ST_WR_ACC: begin
            next_bvalid = 1'b1;
            next_st = ST_WR_RESP;
         end
         ST_RMW_RD: begin
            next_st = ST_RMW_MRG;
         end
         ST_RMW_MRG: begin
            // Address and data are not latched, so ready waits for the merge.
            next_a_en = 1'b1;
            next_a_we = '1;
            next_a_wdata = {enc_chk ^ mask_eff, merged};
            next_awready = 1'b1;
            next_wready = 1'b1;
            next_st = ST_RMW_WR;
         end
         ST_RMW_WR: begin
            next_bvalid = 1'b1;
            next_inj_done = MASK_EN;
            next_st = ST_WR_RESP;
         end
         ST_WR_RESP: begin
            if (s_bready) begin
               next_bvalid = 1'b0;
               next_st = ST_IDLE;
               // A waiting write starts at once; a waiting read goes via idle.
               if (!s_arvalid && s_awvalid && s_wvalid) begin
                  start_wr = 1'b1;
               end
            end
         end
         default: begin
            next_st = ST_IDLE;
         end
      endcase
      if (start_wr) begin
         next_a_en = 1'b1;
         next_a_addr = waddr_w;
         if (ECC_ON) begin
            next_st = ST_RMW_RD;
         end else begin
            next_a_we = s_wstrb;
            next_a_wdata = {{CHK_W{1'b0}}, s_wdata};
            next_awready = 1'b1;
            next_wready = 1'b1;
            next_st = ST_WR_ACC;
         end
      end
   end

   // Register stage; every port output is a flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= ST_IDLE;
         s_arready <= 1'b0;
         s_awready <= 1'b0;
         s_wready <= 1'b0;
         s_bvalid <= 1'b0;
         s_bresp <= LBR_RESP_OKAY;
         s_rvalid <= 1'b0;
         s_rresp <= LBR_RESP_OKAY;
         s_rlast <= 1'b0;
         s_rdata <= '0;
         memory_port_a_enable <= 1'b0;
         mem_a_we <= '0;
         memory_port_a_address <= '0;
         mem_a_wdata <= '0;
         mem_b_en <= 1'b0;
         mem_b_addr <= '0;
         inj_done <= 1'b0;
      end else begin
         st <= next_st;
         s_arready <= next_arready;
         s_awready <= next_awready;
         s_wready <= next_wready;
         s_bvalid <= next_bvalid;
         s_bresp <= LBR_RESP_OKAY;
         s_rvalid <= next_rvalid;
         s_rresp <= LBR_RESP_OKAY;
         s_rlast <= next_rvalid;
         s_rdata <= next_rdata;
         memory_port_a_enable <= next_a_en;
         mem_a_we <= next_a_we;
         memory_port_a_address <= next_a_addr;
         mem_a_wdata <= next_a_wdata;
         mem_b_en <= next_b_en;
         mem_b_addr <= next_b_addr;
         inj_done <= next_inj_done;
      end
   end

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   // Clean check bits of the word being written, for the injection check.
   logic [CHK_W-1:0] chk_ref;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chk_ref <= '0;
      end else begin
         chk_ref <= enc_chk;
      end
   end

   sequence s_rd_issue;
      s_arready ##1 !s_arready ##1 s_rvalid;
   endsequence

   sequence s_rmw_steps;
      !s_awready ##1 !s_awready ##1 (s_awready && s_wready);
   endsequence

   AST_INJECT_CHECK_BITS: assert property (@(posedge pclk) disable iff (!presetn)
      (st == ST_RMW_WR) |-> mem_a_wdata[MEM_W-1:DATA_W] == (chk_ref ^ mask_eff))
      else $error("Written check bits do not carry the fault mask.");

   AST_READ_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
      (st == ST_IDLE && s_arvalid && s_awvalid) |=> s_arready && !s_awready)
      else $error("Write granted over a simultaneous read.");

   AST_ONE_AT_A_TIME: assert property (@(posedge pclk) disable iff (!presetn)
      !(s_arready && s_awready) && !(s_rvalid && s_bvalid))
      else $error("Two transactions in progress.");

   AST_READ_TIMING: assert property (@(posedge pclk) disable iff (!presetn)
      (st == ST_IDLE && s_arvalid) |=> s_rd_issue)
      else $error("Read path timing changed.");

   AST_RMW_READY_HELD: assert property (@(posedge pclk) disable iff (!presetn)
      (ECC_ON && start_wr) |=> s_rmw_steps)
      else $error("Write ready raised before merge completed.");

   AST_B2B_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      (st == ST_WR_RESP && s_bready && s_awvalid && s_wvalid && !s_arvalid)
      |=> memory_port_a_enable && (st == (ECC_ON ? ST_RMW_RD : ST_WR_ACC)))
      else $error("Back-to-back write stalled.");

   AST_IDLE_ENABLES: assert property (@(posedge pclk) disable iff (!presetn)
      (st == ST_IDLE || st == ST_RD_RESP || st == ST_WR_RESP)
      |-> !memory_port_a_enable && !mem_b_en)
      else $error("Memory enable high while bus idle.");

   AST_DUAL_PORT_READ: assert property (@(posedge pclk) disable iff (!presetn)
      (!SINGLE_PORT && s_arready) |-> mem_b_en && !memory_port_a_enable)
      else $error("Dual-port read not on port B.");

   AST_RDATA_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      (s_rvalid && !s_rready) |=> s_rvalid && s_rlast && $stable(s_rdata))
      else $error("Read data dropped before ready.");

endmodule : lbr_ctrl

// ===== tb/lbr_ram_model.sv
// Behavioural block RAM on the controller's far side: port A read/write, port B read.
// Assumes one clock, one cycle read latency and read-before-write on port A.
`timescale 1ns/100ps

module lbr_ram_model #(
   parameter int AW = 11,
   parameter int W = 39
) (
   input wire logic clk, // Memory clock.
   input wire logic a_en, // Port A enable.
   input wire logic [3:0] a_we, // Port A byte write enables.
   input wire logic [AW-1:0] a_addr, // Port A word address.
   input wire logic [W-1:0] a_wdata, // Port A write data.
   output logic [W-1:0] a_rdata, // Port A read data.
   input wire logic b_en, // Port B enable.
   input wire logic [AW-1:0] b_addr, // Port B word address.
   output logic [W-1:0] b_rdata // Port B read data.
);
   logic [W-1:0] mem [0:(1<<AW)-1];
   // -------------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------------
   // Idle ports show the inverse of their last value, so stale data never looks fresh.
   initial begin
      a_rdata = '0;
      b_rdata = '0;
   end
   always @(posedge clk) begin
      a_rdata <= a_en ? mem[a_addr] : ~a_rdata;
      b_rdata <= b_en ? mem[b_addr] : ~b_rdata;
      for (int i = 0; i < 4; i++) begin
         if (a_en && a_we[i]) begin
            mem[a_addr][8*i +: 8] <= a_wdata[8*i +: 8];
         end
      end
      if (a_en && (|a_we)) begin
         mem[a_addr][W-1:32] <= a_wdata[W-1:32]; // Check bits go with any write.
      end
   end
endmodule : lbr_ram_model

// ===== tb/lbr_ctrl_tb_top.sv
// Self-checking bench for the block RAM controller in its default configuration.
// Assumes 32-bit data, ECC and fault injection on, and one memory port.
`timescale 1ns/100ps

module lbr_ctrl_tb_top;
   import lbr_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [LBR_PADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd, s_awaddr, s_araddr, s_wdata, s_rdata;
   logic [3:0] s_wstrb, a_we;
   logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic s_arvalid, s_arready, s_rlast, s_rvalid, s_rready, a_en, b_en;
   logic [1:0] s_bresp, s_rresp;
   logic [10:0] a_addr, b_addr;
   logic [38:0] a_wd, a_rd, b_rd;
   int n_mismatch, total_checks;
   lbr_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
      .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
      .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
      .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
      .s_rlast(s_rlast), .s_rvalid(s_rvalid), .s_rready(s_rready),
      .memory_port_a_enable(a_en), .mem_a_we(a_we), .memory_port_a_address(a_addr),
      .mem_a_wdata(a_wd), .memory_port_a_read_data(a_rd), .mem_b_en(b_en),
      .mem_b_addr(b_addr), .mem_b_rdata(b_rd));
   lbr_ram_model u_mem (.clk(pclk), .a_en(a_en), .a_we(a_we), .a_addr(a_addr),
      .a_wdata(a_wd), .a_rdata(a_rd), .b_en(b_en), .b_addr(b_addr), .b_rdata(b_rd));
   // -------------------------------------------------------------------
   // Clock, reset and watchdog
   // -------------------------------------------------------------------
   initial begin
      pclk = 1'h0;
      forever #50 pclk = ~pclk;
   end
   // A hung handshake would stall forever, so the watchdog ends the run.
   initial begin
      #2000000;
      n_mismatch++;
      end_sim();
   end
   // -------------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; the request is held until pready is seen at an edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // One idle edge, so a following call never reassigns psel in this time step.
      @(posedge pclk);
   endtask : apb
   // One AXI4-Lite write; address and data are held until awready is seen, and wready is checked at that edge.
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'h1;
      s_wvalid <= 1'h1;
      s_bready <= 1'h1;
      do @(posedge pclk); while (s_awready !== 1'h1);
      chk(s_wready, 1'h1);
      s_awvalid <= 1'h0;
      s_wvalid <= 1'h0;
      do @(posedge pclk); while (s_bvalid !== 1'h1);
      chk(s_bresp, LBR_RESP_OKAY);
      s_bready <= 1'h0;
   endtask : axi_wr
   task automatic axi_rd(input logic [31:0] a);
      s_araddr <= a;
      s_arvalid <= 1'h1;
      do @(posedge pclk); while (s_arready !== 1'h1);
      s_arvalid <= 1'h0;
      do @(posedge pclk); while (s_rvalid !== 1'h1);
      // Ready comes a cycle late, so the response must stand over one edge.
      s_rready <= 1'h1;
      @(posedge pclk);
      rd = s_rdata;
      chk(s_rvalid, 1'h1);
      chk(s_rlast, 1'h1);
      chk(s_rresp, LBR_RESP_OKAY);
      s_rready <= 1'h0;
   endtask : axi_rd
   task automatic t_regs;
      apb(1'h0, LBR_MASK_OFS, 32'h0);
      chk({er, rd}, 33'h0);
      apb(1'h1, LBR_MASK_OFS, 32'hFFFFFFFF);
      apb(1'h0, LBR_MASK_OFS, 32'h0);
      chk(rd, 32'h7F);
      apb(1'h0, LBR_STAT_OFS, 32'h0);
      chk(rd[4:2], 3'h7);
      apb(1'h0, 12'h008, 32'h0);
      chk(er, 1'h1);
      $display("test regs done");
   endtask : t_regs
   // Two writes of one word, the second with a mask, differ only in check bits.
   task automatic t_inject;
      apb(1'h1, LBR_MASK_OFS, 32'h0);
      axi_wr(32'h0, 32'hC3A51E77);
      apb(1'h1, LBR_MASK_OFS, 32'h15);
      axi_wr(32'h4, 32'hC3A51E77);
      chk(u_mem.mem[1][38:32] ^ u_mem.mem[0][38:32], 7'h15);
      chk(u_mem.mem[1][31:0], 32'hC3A51E77);
      apb(1'h0, LBR_MASK_OFS, 32'h0);
      chk(rd, 32'h0);
      axi_wr(32'h8, 32'hC3A51E77);
      chk(u_mem.mem[2], u_mem.mem[0]);
      axi_rd(32'h4);
      chk(rd, 32'hC3A51E77);
      $display("test inject done");
   endtask : t_inject
   // Read and write presented together: the read is granted first.
   task automatic t_prio;
      @(posedge pclk);
      s_araddr <= 32'h0;
      s_awaddr <= 32'h0C;
      s_wdata <= 32'h5A5A0F0F;
      s_arvalid <= 1'h1;
      s_awvalid <= 1'h1;
      s_wvalid <= 1'h1;
      s_rready <= 1'h1;
      s_bready <= 1'h1;
      do @(posedge pclk); while (s_arready !== 1'h1 && s_awready !== 1'h1);
      chk({s_arready, s_awready}, 2'h2);
      s_arvalid <= 1'h0;
      do @(posedge pclk); while (s_awready !== 1'h1);
      // Valid stays up with a new word, so the next read-modify-write starts at the response edge.
      s_awaddr <= 32'h10;
      s_wdata <= 32'h3C3C00FF;
      do @(posedge pclk); while (s_bvalid !== 1'h1);
      repeat (3) @(posedge pclk);
      chk(s_awready, 1'h1);
      s_awvalid <= 1'h0;
      s_wvalid <= 1'h0;
      do @(posedge pclk); while (s_bvalid !== 1'h1);
      s_bready <= 1'h0;
      s_rready <= 1'h0;
      chk(u_mem.mem[3][31:0], 32'h5A5A0F0F);
      chk(u_mem.mem[4][31:0], 32'h3C3C00FF);
      repeat (4) @(posedge pclk);
      chk({a_en, b_en}, 2'h0);
      $display("test priority done");
   endtask : t_prio
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim
   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {s_awaddr, s_araddr, s_wdata, s_awvalid, s_wvalid, s_bready} = '0;
      {s_arvalid, s_rready} = '0;
      s_wstrb = 4'hF;
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      t_regs();
      t_inject();
      t_prio();
      end_sim();
   end
endmodule : lbr_ctrl_tb_top
